// [src/gpapc_top.sv]
// Twelve multi-function pins with APB configuration, ISA decode and power control.
`timescale 1ns/1ns
`include "gpapc_defines.svh"
//
// Function
// - Upper polarity bits 3-0 invert their pin when 1; bits 7-4 reserved.
// - Upper function select bit 1 gives simple I/O, 0 alternate function.
// - Upper direction bit 1 makes a simple I/O pin input, 0 output.
// - Ring location 000 none, 010 to 110 select pins 2 to 6.
// - Power-off request location: even codes pins 8-11, odd codes pins 0-7.
// - A pin drives no output, interrupt or ring wake unless its global enable bit is set.
// - Simple I/O data sits at host ports base and base plus one.
// - Single-port bit 4 uses base only; bit 5 picks the group.
// - Every alternate function but ring wake can go to any pin.
// - Each chip select decodes 1, 2, 4 or 8 ports from its base.
// - Chip select qualifies on address, with read, with write, or either.
// - Zero wait is signalled when an enabled logical device is accessed.
// - An interrupt on a mapped pin drives the chosen ISA level.
// - Power-off request drives its pin; ring wake samples its pin.
// - Main power enable asserts on power-on and drops on power-off events.
// - When off, ring indicator rises, ring pulses or button power on.
// - When on, button or software off bit power off.
// - Button counts only after staying low at least 16 ms.
// - After button off, power stays on 5 or 21 seconds.
// - Hold bit freezes the switch-off delay counter.
// - A train of low pulses on the ring pin is a wake event.
module gpapc_top #(
	parameter int N_PINS = 12,
	parameter logic [31:0] DEBOUNCE_CYC = 32'(`GPAPC_DEBOUNCE_MS * `GPAPC_CLK_HZ / 64'd1000),
	parameter logic [31:0] DELAY_SHORT_CYC = 32'(`GPAPC_DELAY_SHORT_S * `GPAPC_CLK_HZ),
	parameter logic [31:0] DELAY_LONG_CYC = 32'(`GPAPC_DELAY_LONG_S * `GPAPC_CLK_HZ),
	parameter logic [7:0] RING_PULSES = `GPAPC_RING_PULSES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire gpapc_pkg::gpapc_isa_s isa,
	input wire logic [6:0] dev_access,
	output logic [7:0] isa_rdata,
	output logic isa_rdata_oe,
	output logic isa_zero_wait_n,
	output logic [15:0] isa_irq,
	input wire logic [11:0] gpio_in,
	output logic [11:0] gpio_out,
	output logic [11:0] gpio_oe,
	input wire logic user_interface_pin_zero,
	input wire logic ring_indicator_one,
	input wire logic ring_indicator_two,
	output logic main_power_enable_n
);
	import gpapc_pkg::*;
	// ----------------------------------------
	// Parameter check
	// ----------------------------------------
	// Location codes cover exactly twelve pins, so no other count is served.
	if (N_PINS != 12) begin : g_bad
		$error("gpapc_top: N_PINS must be 12");
	end
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	gpapc_top_s st;
	gpapc_top_s next_st;
	logic [7:0] idx;
	logic [31:0] rd_val;
	logic rd_ok;
	logic [2:0] cs_hit;
	logic sio_hit;
	logic sio_lo;
	logic isa_act;
	logic gpio_acc;
	logic [11:0] pin_lvl;
	logic [11:0] alt_out;
	logic [11:0] alt_oe;
	logic [11:0] irq_src;
	logic [11:0] sio_rd;
	logic ring_lvl;
	logic por_n;
	gpapc_pwr_e pwr_state;
	logic [11:0] base_p1;
	logic zws_now_n;
	// ----------------------------------------
	// Pin logic
	// ----------------------------------------
	assign idx = paddr[9:2];
	assign pin_lvl = gpio_in ^ st.cfg.pol;
	for (genvar i = 0; i < 12; i++) begin : g_pin
		// Upper pins take the even codes, lower pins the odd ones.
		localparam logic [3:0] CODE = (i >= 8) ? 4'(2 * (i - 7)) : 4'(2 * i + 1);
		logic alt;
		logic [4:0] hit;
		logic [4:0] val_n;
		// Alternate mode when select is 0.
		assign alt = st.cfg.pin_en[i] && !st.cfg.fsel[i];
		assign hit[0] = st.cfg.cs[0].loc == CODE;
		assign hit[1] = st.cfg.cs[1].loc == CODE;
		assign hit[2] = st.cfg.cs[2].loc == CODE;
		assign hit[3] = st.cfg.zws_loc == CODE;
		assign hit[4] = st.cfg.por_loc == CODE;
		assign val_n = {por_n, zws_now_n, ~cs_hit};
		// Several functions on one pin share it as a wired low.
		assign alt_oe[i] = alt && (|hit);
		assign alt_out[i] = &(val_n | ~hit);
		assign irq_src[i] = alt && st.cfg.irq_loc == CODE && pin_lvl[i];
		assign sio_rd[i] = (st.cfg.fsel[i] && st.cfg.dir[i]) ? pin_lvl[i] : st.cfg.sio_data[i];
	end
	// Ring pin, codes 2 to 6 only.
	always_comb begin
		ring_lvl = 1'b1;
		if (st.cfg.ring_loc >= 3'd2 && st.cfg.ring_loc <= 3'd6) begin
			if (st.cfg.pin_en[st.cfg.ring_loc] && !st.cfg.fsel[st.cfg.ring_loc]) begin
				ring_lvl = pin_lvl[st.cfg.ring_loc];
			end
		end
	end
	// ----------------------------------------
	// ISA decode
	// ----------------------------------------
	assign isa_act = !isa.ior_n || !isa.iow_n;
	for (genvar k = 0; k < 3; k++) begin : g_cs
		logic [11:0] mask;
		logic qual;
		assign mask = 12'hfff << st.cfg.cs[k].align;
		always_comb begin
			unique case (st.cfg.cs[k].qual)
				2'd0: qual = 1'b1;
				2'd1: qual = !isa.ior_n;
				2'd2: qual = !isa.iow_n;
				2'd3: qual = isa_act;
			endcase
		end
		assign cs_hit[k] = isa.addr[15:12] == 4'h0 && qual
			&& (isa.addr[11:0] & mask) == (st.cfg.cs[k].base & mask);
	end
	assign base_p1 = st.cfg.sio_base + 12'h001;
	always_comb begin
		sio_hit = 1'b0;
		sio_lo = 1'b1;
		if (isa.addr[15:12] == 4'h0) begin
			if (st.cfg.sio_single) begin
				sio_hit = isa.addr[11:0] == st.cfg.sio_base;
				sio_lo = st.cfg.sio_group_lo;
			end else if (isa.addr[11:0] == st.cfg.sio_base) begin
				sio_hit = 1'b1;
			end else if (isa.addr[11:0] == base_p1) begin
				sio_hit = 1'b1;
				sio_lo = 1'b0;
			end
		end
	end
	assign gpio_acc = isa_act && (sio_hit || (|cs_hit));
	// Zero wait term, shared by the pin and the bus output so no loop forms.
	assign zws_now_n = !((st.cfg.zws_en[`GPAPC_ZWS_GPIO_BIT] && gpio_acc)
		|| (isa_act && |(st.cfg.zws_en[6:0] & dev_access)));
	// ----------------------------------------
	// Register read mux
	// ----------------------------------------
	// Reserved bits read zero; the pin levels in status ignore polarity on purpose.
	always_comb begin
		rd_ok = 1'b1;
		rd_val = 32'h0000_0000;
		unique case (idx)
			`GPAPC_IDX_PIN_EN_LO: rd_val[7:0] = st.cfg.pin_en[7:0];
			`GPAPC_IDX_PIN_EN_HI: rd_val[3:0] = st.cfg.pin_en[11:8];
			`GPAPC_IDX_SIO_MSB: rd_val[3:0] = st.cfg.sio_base[11:8];
			`GPAPC_IDX_SIO_LSB: rd_val[7:0] = st.cfg.sio_base[7:0];
			`GPAPC_IDX_IRQ_SEL: rd_val[7:0] = {st.cfg.irq_loc, st.cfg.irq_level};
			`GPAPC_IDX_PWR_SOFT: rd_val = 32'h0000_0000;
			`GPAPC_IDX_PWR_TIMER: begin
				rd_val[`GPAPC_HOLD_BIT] = st.cfg.hold;
				rd_val[`GPAPC_DSEL_BIT] = st.cfg.delay_long;
			end
			`GPAPC_IDX_STATUS: rd_val[13:0] = {pwr_state == PWR_DELAY, !main_power_enable_n, gpio_in};
			`GPAPC_IDX_POL_LO: rd_val[7:0] = st.cfg.pol[7:0];
			`GPAPC_IDX_FSEL_LO: rd_val[7:0] = st.cfg.fsel[7:0];
			`GPAPC_IDX_DIR_LO: rd_val[7:0] = st.cfg.dir[7:0];
			`GPAPC_IDX_ZWS_CTRL: rd_val[5:0] = {st.cfg.sio_group_lo, st.cfg.sio_single, st.cfg.zws_loc};
			`GPAPC_IDX_ZWS_EN: rd_val[7:0] = st.cfg.zws_en;
			`GPAPC_IDX_POL_HI: rd_val[3:0] = st.cfg.pol[11:8];
			`GPAPC_IDX_FSEL_HI: rd_val[3:0] = st.cfg.fsel[11:8];
			`GPAPC_IDX_DIR_HI: rd_val[3:0] = st.cfg.dir[11:8];
			`GPAPC_IDX_PWR_LOC: rd_val[6:0] = {st.cfg.ring_loc, st.cfg.por_loc};
			default: rd_ok = 1'b0;
		endcase
		for (int k = 0; k < 3; k++) begin
			if (idx == 8'(`GPAPC_IDX_CS_MSB0 + 2 * k)) begin
				rd_ok = 1'b1;
				rd_val[3:0] = st.cfg.cs[k].base[11:8];
			end
			if (idx == 8'(`GPAPC_IDX_CS_MSB0 + 2 * k + 1)) begin
				rd_ok = 1'b1;
				rd_val[7:0] = st.cfg.cs[k].base[7:0];
			end
			if (idx == 8'(`GPAPC_IDX_CS_CTRL0 + k)) begin
				rd_ok = 1'b1;
				rd_val[7:0] = {st.cfg.cs[k].align, st.cfg.cs[k].qual, st.cfg.cs[k].loc};
			end
		end
	end
	// ----------------------------------------
	// Next state
	// ----------------------------------------
	// APB answers with no wait: data and error are captured in the setup cycle.
	always_comb begin
		next_st = st;
		next_st.soft_off = 1'b0;
		if (psel && !penable) begin
			next_st.prdata = rd_val;
			next_st.slverr = !rd_ok;
		end
		if (psel && penable && pwrite && rd_ok) begin
			unique case (idx)
				`GPAPC_IDX_PIN_EN_LO: next_st.cfg.pin_en[7:0] = pwdata[7:0];
				`GPAPC_IDX_PIN_EN_HI: next_st.cfg.pin_en[11:8] = pwdata[3:0];
				`GPAPC_IDX_SIO_MSB: next_st.cfg.sio_base[11:8] = pwdata[3:0];
				`GPAPC_IDX_SIO_LSB: next_st.cfg.sio_base[7:0] = pwdata[7:0];
				`GPAPC_IDX_IRQ_SEL: {next_st.cfg.irq_loc, next_st.cfg.irq_level} = pwdata[7:0];
				`GPAPC_IDX_PWR_SOFT: next_st.soft_off = pwdata[`GPAPC_SOFT_OFF_BIT];
				`GPAPC_IDX_PWR_TIMER: begin
					next_st.cfg.hold = pwdata[`GPAPC_HOLD_BIT];
					next_st.cfg.delay_long = pwdata[`GPAPC_DSEL_BIT];
				end
				`GPAPC_IDX_POL_LO: next_st.cfg.pol[7:0] = pwdata[7:0];
				`GPAPC_IDX_FSEL_LO: next_st.cfg.fsel[7:0] = pwdata[7:0];
				`GPAPC_IDX_DIR_LO: next_st.cfg.dir[7:0] = pwdata[7:0];
				`GPAPC_IDX_ZWS_CTRL: begin
					next_st.cfg.sio_group_lo = pwdata[`GPAPC_SIO_GROUP_BIT];
					next_st.cfg.sio_single = pwdata[`GPAPC_SIO_SINGLE_BIT];
					next_st.cfg.zws_loc = pwdata[3:0];
				end
				`GPAPC_IDX_ZWS_EN: next_st.cfg.zws_en = pwdata[7:0];
				`GPAPC_IDX_POL_HI: next_st.cfg.pol[11:8] = pwdata[3:0];
				`GPAPC_IDX_FSEL_HI: next_st.cfg.fsel[11:8] = pwdata[3:0];
				`GPAPC_IDX_DIR_HI: next_st.cfg.dir[11:8] = pwdata[3:0];
				`GPAPC_IDX_PWR_LOC: {next_st.cfg.ring_loc, next_st.cfg.por_loc} = pwdata[6:0];
				default: ;
			endcase
			for (int k = 0; k < 3; k++) begin
				if (idx == 8'(`GPAPC_IDX_CS_MSB0 + 2 * k)) begin
					next_st.cfg.cs[k].base[11:8] = pwdata[3:0];
				end
				if (idx == 8'(`GPAPC_IDX_CS_MSB0 + 2 * k + 1)) begin
					next_st.cfg.cs[k].base[7:0] = pwdata[7:0];
				end
				if (idx == 8'(`GPAPC_IDX_CS_CTRL0 + k)) begin
					{next_st.cfg.cs[k].align, next_st.cfg.cs[k].qual} = pwdata[7:4];
					next_st.cfg.cs[k].loc = pwdata[3:0];
				end
			end
		end
		// Host writes data on the write strobe's falling edge.
		next_st.iow_prev = isa.iow_n;
		if (st.iow_prev && !isa.iow_n && sio_hit) begin
			if (sio_lo) begin
				next_st.cfg.sio_data[7:0] = isa.wdata;
			end else begin
				next_st.cfg.sio_data[11:8] = isa.wdata[3:0];
			end
		end
		next_st.isa_rdata = sio_lo ? sio_rd[7:0] : {4'h0, sio_rd[11:8]};
		next_st.isa_rdata_oe = !isa.ior_n && sio_hit;
		// Zero wait registered for the bus.
		next_st.zws_n = zws_now_n;
		// Route to the chosen level; 0, 2 and 13 up are not valid.
		next_st.irq = 16'h0000;
		if (st.cfg.irq_level != 4'd0 && st.cfg.irq_level != 4'd2 && st.cfg.irq_level <= 4'd12) begin
			next_st.irq[st.cfg.irq_level] = |irq_src;
		end
		for (int i = 0; i < 12; i++) begin
			if (st.cfg.pin_en[i] && st.cfg.fsel[i]) begin
				next_st.pin_oe[i] = !st.cfg.dir[i];
				next_st.pin_out[i] = st.cfg.sio_data[i] ^ st.cfg.pol[i];
			end else begin
				next_st.pin_oe[i] = alt_oe[i];
				next_st.pin_out[i] = alt_out[i] ^ st.cfg.pol[i];
			end
		end
	end
	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '{zws_n: 1'b1, iow_prev: 1'b1, default: '0};
		end else begin
			st <= next_st;
		end
	end
	// ----------------------------------------
	// Power control and outputs
	// ----------------------------------------
	gpapc_power #(
		.DEBOUNCE_CYC(DEBOUNCE_CYC),
		.DELAY_SHORT_CYC(DELAY_SHORT_CYC),
		.DELAY_LONG_CYC(DELAY_LONG_CYC),
		.RING_PULSES(RING_PULSES)
	) i_gpapc_power (
		.pclk(pclk),
		.presetn(presetn),
		.switch_n(user_interface_pin_zero),
		.ring_indicator_one(ring_indicator_one),
		.ring_indicator_two(ring_indicator_two),
		.ring_wake(ring_lvl),
		.soft_off(st.soft_off),
		.hold(st.cfg.hold),
		.delay_long(st.cfg.delay_long),
		.main_power_enable_n(main_power_enable_n),
		.power_off_request_n(por_n),
		.power_state(pwr_state)
	);
	assign pready = 1'b1;
	assign prdata = st.prdata;
	assign pslverr = psel && penable && st.slverr;
	assign isa_rdata = st.isa_rdata;
	assign isa_rdata_oe = st.isa_rdata_oe;
	assign isa_zero_wait_n = st.zws_n;
	assign isa_irq = st.irq;
	assign gpio_out = st.pin_out;
	assign gpio_oe = st.pin_oe;
endmodule : gpapc_top

// [src/gpapc_defines.svh]
// Register indices, field positions, reset value and timing figures of the pin block.
`ifndef GPAPC_DEFINES_SVH
`define GPAPC_DEFINES_SVH
// ----------------------------------------
// Register indices (byte address = 4 x index)
// ----------------------------------------
`define GPAPC_IDX_PIN_EN_LO 8'h25
`define GPAPC_IDX_PIN_EN_HI 8'h26
`define GPAPC_IDX_CS_MSB0 8'h60
`define GPAPC_IDX_SIO_MSB 8'h66
`define GPAPC_IDX_SIO_LSB 8'h67
`define GPAPC_IDX_IRQ_SEL 8'h70
`define GPAPC_IDX_PWR_SOFT 8'h90
`define GPAPC_IDX_PWR_TIMER 8'h92
`define GPAPC_IDX_STATUS 8'h94
`define GPAPC_IDX_POL_LO 8'hf0
`define GPAPC_IDX_CS_CTRL0 8'hf1
`define GPAPC_IDX_FSEL_LO 8'hf4
`define GPAPC_IDX_DIR_LO 8'hf5
`define GPAPC_IDX_ZWS_CTRL 8'hf6
`define GPAPC_IDX_ZWS_EN 8'hf7
`define GPAPC_IDX_POL_HI 8'hf8
`define GPAPC_IDX_FSEL_HI 8'hf9
`define GPAPC_IDX_DIR_HI 8'hfa
`define GPAPC_IDX_PWR_LOC 8'hfb
// ----------------------------------------
// Field positions and reset value
// ----------------------------------------
`define GPAPC_SIO_SINGLE_BIT 4
`define GPAPC_SIO_GROUP_BIT 5
`define GPAPC_ZWS_GPIO_BIT 7
`define GPAPC_SOFT_OFF_BIT 5
`define GPAPC_HOLD_BIT 6
`define GPAPC_DSEL_BIT 0
`define GPAPC_REG_RESET 8'h00
// ----------------------------------------
// Timing
// ----------------------------------------
`define GPAPC_CLK_HZ 64'd100000000
`define GPAPC_DEBOUNCE_MS 64'd16
`define GPAPC_DELAY_SHORT_S 64'd5
`define GPAPC_DELAY_LONG_S 64'd21
`define GPAPC_RING_PULSES 8'd1
`endif

// [src/gpapc_pkg.sv]
// Types shared by the pin block and its power control module.
package gpapc_pkg;
	typedef enum logic [1:0] {PWR_OFF, PWR_ON, PWR_DELAY} gpapc_pwr_e;
	typedef struct packed {
		logic [15:0] addr;
		logic ior_n;
		logic iow_n;
		logic [7:0] wdata;
	} gpapc_isa_s;
	typedef struct packed {
		logic [11:0] base;
		logic [1:0] align;
		logic [1:0] qual;
		logic [3:0] loc;
	} gpapc_cs_s;
	typedef struct packed {
		logic [11:0] pin_en;
		logic [11:0] pol;
		logic [11:0] fsel;
		logic [11:0] dir;
		logic [11:0] sio_data;
		logic [11:0] sio_base;
		logic sio_single;
		logic sio_group_lo;
		logic [3:0] zws_loc;
		logic [7:0] zws_en;
		logic [3:0] irq_loc;
		logic [3:0] irq_level;
		gpapc_cs_s [2:0] cs;
		logic [2:0] ring_loc;
		logic [3:0] por_loc;
		logic hold;
		logic delay_long;
	} gpapc_cfg_s;
	typedef struct packed {
		gpapc_cfg_s cfg;
		logic [31:0] prdata;
		logic slverr;
		logic [11:0] pin_out;
		logic [11:0] pin_oe;
		logic [7:0] isa_rdata;
		logic isa_rdata_oe;
		logic zws_n;
		logic [15:0] irq;
		logic iow_prev;
		logic soft_off;
	} gpapc_top_s;
	typedef struct packed {
		gpapc_pwr_e state;
		logic [31:0] deb_cnt;
		logic deb_done;
		logic [31:0] dly_cnt;
		logic [7:0] ring_cnt;
		logic ring_prev;
		logic ri1_prev;
		logic ri2_prev;
		logic en_n;
		logic req_n;
	} gpapc_pwr_s;
endpackage : gpapc_pkg

// [src/gpapc_power.sv]
// Main power sequencer: button debounce, ring wake and switch-off delay.
`timescale 1ns/1ns
`include "gpapc_defines.svh"
module gpapc_power #(
	parameter logic [31:0] DEBOUNCE_CYC = 32'(`GPAPC_DEBOUNCE_MS * `GPAPC_CLK_HZ / 64'd1000),
	parameter logic [31:0] DELAY_SHORT_CYC = 32'(`GPAPC_DELAY_SHORT_S * `GPAPC_CLK_HZ),
	parameter logic [31:0] DELAY_LONG_CYC = 32'(`GPAPC_DELAY_LONG_S * `GPAPC_CLK_HZ),
	parameter logic [7:0] RING_PULSES = `GPAPC_RING_PULSES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic switch_n,
	input wire logic ring_indicator_one,
	input wire logic ring_indicator_two,
	input wire logic ring_wake,
	input wire logic soft_off,
	input wire logic hold,
	input wire logic delay_long,
	output logic main_power_enable_n,
	output logic power_off_request_n,
	output gpapc_pkg::gpapc_pwr_e power_state
);
	import gpapc_pkg::*;
	if (DEBOUNCE_CYC == 32'd0 || DELAY_SHORT_CYC == 32'd0 || DELAY_LONG_CYC == 32'd0
		|| RING_PULSES == 8'd0) begin : g_bad
		$error("gpapc_power: counts must be at least one");
	end
	gpapc_pwr_s st;
	gpapc_pwr_s next_st;
	logic button;
	logic on_evt;
	// Sequencer; every event is judged on the state it arrives in.
	always_comb begin
		next_st = st;
		button = 1'b0;
		next_st.ring_prev = ring_wake;
		next_st.ri1_prev = ring_indicator_one;
		next_st.ri2_prev = ring_indicator_two;
		// Button debounce.
		// One event per press: the input must go high again to rearm.
		if (switch_n) begin
			next_st.deb_cnt = 32'd0;
			next_st.deb_done = 1'b0;
		end else if (st.deb_cnt != DEBOUNCE_CYC - 32'd1) begin
			next_st.deb_cnt = st.deb_cnt + 32'd1;
		end else if (!st.deb_done) begin
			button = 1'b1;
			next_st.deb_done = 1'b1;
		end
		if (st.state != PWR_OFF) begin
			next_st.ring_cnt = 8'd0;
		end else if (st.ring_prev && !ring_wake) begin
			next_st.ring_cnt = st.ring_cnt + 8'd1;
		end
		on_evt = button || (ring_indicator_one && !st.ri1_prev)
			|| (ring_indicator_two && !st.ri2_prev) || (next_st.ring_cnt >= RING_PULSES);
		unique case (st.state)
			PWR_OFF: begin
				if (on_evt) begin
					next_st.state = PWR_ON;
				end
			end
			PWR_ON: begin
				if (soft_off) begin
					next_st.state = PWR_OFF;
				end else if (button) begin
					next_st.dly_cnt = delay_long ? DELAY_LONG_CYC - 32'd1 : DELAY_SHORT_CYC - 32'd1;
					next_st.state = PWR_DELAY;
				end
			end
			PWR_DELAY: begin
				if (soft_off || st.dly_cnt == 32'd0) begin
					next_st.state = PWR_OFF;
				end else if (!hold) begin
					next_st.dly_cnt = st.dly_cnt - 32'd1;
				end
			end
		endcase
		next_st.en_n = (next_st.state == PWR_OFF);
		next_st.req_n = (next_st.state != PWR_DELAY);
	end
	// State register; power stays off after reset.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '{state: PWR_OFF, en_n: 1'b1, req_n: 1'b1, ring_prev: 1'b1, default: '0};
		end else begin
			st <= next_st;
		end
	end
	assign main_power_enable_n = st.en_n;
	assign power_off_request_n = st.req_n;
	assign power_state = st.state;
endmodule : gpapc_power

// [test/gpapc_top_assertions.sv]
// Port-level checks for the pin block, bound into the top module.
`timescale 1ns/1ns
`include "gpapc_defines.svh"
module gpapc_top_chk #(
	parameter logic [31:0] DEBOUNCE_CYC = 32'h14
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire gpapc_pkg::gpapc_isa_s isa,
	input wire logic isa_rdata_oe,
	input wire logic [15:0] isa_irq,
	input wire logic [11:0] gpio_in,
	input wire logic user_interface_pin_zero,
	input wire logic ring_indicator_one,
	input wire logic ring_indicator_two,
	input wire logic main_power_enable_n
);
	import gpapc_pkg::*;
	logic [31:0] low_cnt;
	logic [3:0] since_wake;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ----------------------------------------
	// Helpers and assertions
	// ----------------------------------------
	// Button low run length, and cycles since any ring style wake cause.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_cnt <= 32'h0;
			since_wake <= 4'hf;
		end else begin
			low_cnt <= user_interface_pin_zero ? 32'h0 : low_cnt + 32'h1;
			if ($rose(ring_indicator_one) || $rose(ring_indicator_two)
				|| |($past(gpio_in) & ~gpio_in)) begin
				since_wake <= 4'h0;
			end else if (since_wake != 4'hf) begin
				since_wake <= since_wake + 4'h1;
			end
		end
	end
	AST_PREADY_HIGH: assert property (psel |-> pready)
		else $error("pready low in a transfer");
	AST_ERR_IN_ACCESS: assert property (pslverr |-> psel && penable)
		else $error("pslverr outside access");
	AST_RDATA_HOLD: assert property (!(psel && !penable) |=> $stable(prdata))
		else $error("prdata moved outside setup");
	AST_SIO_READ_DRIVE: assert property (isa_rdata_oe |-> !$past(isa.ior_n))
		else $error("read data driven without read strobe");
	AST_IRQ_ONE_LEVEL: assert property ($onehot0(isa_irq))
		else $error("more than one irq level driven");
	AST_RI_WAKE: assert property (main_power_enable_n && ($rose(ring_indicator_one)
		|| $rose(ring_indicator_two)) |-> ##[1:4] !main_power_enable_n)
		else $error("ring indicator did not wake");
	AST_SOFT_OFF: assert property (psel && penable && pwrite
		&& paddr[9:2] == `GPAPC_IDX_PWR_SOFT && pwdata[`GPAPC_SOFT_OFF_BIT]
		|-> ##[1:3] main_power_enable_n)
		else $error("software off ignored");
	AST_BTN_DEBOUNCED: assert property ($fell(main_power_enable_n) |-> since_wake < 4'h8
		|| low_cnt >= DEBOUNCE_CYC - 32'h2 || $past(low_cnt) >= DEBOUNCE_CYC - 32'h2)
		else $error("power on without debounced cause");
endmodule : gpapc_top_chk

bind gpapc_top gpapc_top_chk #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) i_gpapc_top_chk (.pclk, .presetn,
	.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .isa,
	.isa_rdata_oe, .isa_irq, .gpio_in, .user_interface_pin_zero, .ring_indicator_one,
	.ring_indicator_two, .main_power_enable_n);

// [test/gpapc_board.sv]
// Board model: pulled-up pins shared wired-low with external logic.
`timescale 1ns/1ns
module gpapc_board (
	input wire logic [11:0] gpio_out,
	input wire logic [11:0] gpio_oe,
	input wire logic [11:0] ext_drv_n,
	output logic [11:0] gpio_in
);
	// A low from either party wins; a released pin floats up to 1, never to the last value.
	assign gpio_in = ~((gpio_oe & ~gpio_out) | ~ext_drv_n);
endmodule : gpapc_board

// [test/gpapc_top_tb.sv]
// Self-checking bench for the pin block.
`timescale 1ns/1ns
`include "gpapc_defines.svh"
module gpapc_top_tb;
	import gpapc_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, isa_rdata_oe, zwn, mpe_n;
	gpapc_isa_s isa = '{16'h0, 1'h1, 1'h1, 8'h0};
	logic [6:0] dev_access = 7'h0;
	logic [7:0] isa_rdata;
	logic [15:0] isa_irq;
	logic [11:0] gpio_out, gpio_oe, gpio_in;
	logic [11:0] ext_n = 12'hfff;
	logic btn_n = 1, ri1 = 0, ri2 = 0;
	int miscompares = 0, tests_run = 0;
	// ----------------------------------------
	// Clock, design and board
	// ----------------------------------------
	// Counts are shortened so that every delay is seen in a short run.
	always #5 pclk = ~pclk;
	gpapc_top #(.DEBOUNCE_CYC(32'h14), .DELAY_SHORT_CYC(32'h32), .DELAY_LONG_CYC(32'h5a),
		.RING_PULSES(8'h1)) i_gpapc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .isa, .dev_access, .isa_rdata, .isa_rdata_oe,
		.isa_zero_wait_n(zwn), .isa_irq, .gpio_in, .gpio_out, .gpio_oe,
		.user_interface_pin_zero(btn_n), .ring_indicator_one(ri1),
		.ring_indicator_two(ri2), .main_power_enable_n(mpe_n));
	gpapc_board i_gpapc_board (.gpio_out, .gpio_oe, .ext_drv_n(ext_n), .gpio_in);
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic test_done();
		$display("Compares %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : test_done
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Setup, then access held until pready; two idle edges let pin outputs land.
	task automatic apb(input logic w, input logic [7:0] i, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		psel <= 1;
		pwrite <= w;
		paddr <= {2'h0, i, 2'h0};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		if (pready !== 1'h1) begin
			miscompares++;
			test_done();
		end
		q = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
		repeat (2) @(posedge pclk);
	endtask : apb
	task automatic wr(input logic [7:0] i, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'h1, i, d, q, e);
	endtask : wr
	task automatic rdc(input logic [7:0] i, input logic [31:0] x, input logic xe);
		logic [31:0] q;
		logic e;
		apb(1'h0, i, 32'h0, q, e);
		chk(q, x);
		chk(e, xe);
	endtask : rdc
	task automatic isa_io(input logic [15:0] a, input logic rd, input logic [7:0] d,
		output logic [7:0] q);
		isa <= '{a, !rd, rd, d};
		repeat (3) @(posedge pclk);
		q = isa_rdata;
		chk(isa_rdata_oe, rd);
		isa <= '{16'h0, 1'h1, 1'h1, 8'h0};
		repeat (3) @(posedge pclk);
	endtask : isa_io
	task automatic press(input int n);
		btn_n <= 0;
		repeat (n) @(posedge pclk);
		btn_n <= 1;
		@(posedge pclk);
	endtask : press
	task automatic wait_pwr(input logic exp, input int lo, input int hi);
		int n;
		for (n = 0; n < hi && mpe_n !== exp; n++)
			@(posedge pclk);
		chk(mpe_n, exp);
		chk(n >= lo, 1'h1);
		if (mpe_n !== exp)
			test_done();
	endtask : wait_pwr
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_regs();
		rdc(`GPAPC_IDX_POL_HI, 32'h0, 1'h0);
		rdc(`GPAPC_IDX_FSEL_HI, 32'h0, 1'h0);
		rdc(`GPAPC_IDX_DIR_HI, 32'h0, 1'h0);
		wr(`GPAPC_IDX_PWR_LOC, 32'h6f);
		rdc(`GPAPC_IDX_PWR_LOC, 32'h6f, 1'h0);
		wr(8'h00, 32'hff);
		rdc(8'h00, 32'h0, 1'h1);
	endtask : t_regs
	task automatic t_sio();
		logic [7:0] q;
		wr(`GPAPC_IDX_SIO_MSB, 32'h02);
		wr(`GPAPC_IDX_FSEL_HI, 32'h0f);
		isa_io(16'h0201, 1'h0, 8'h00, q);
		chk(gpio_in[11:8], 4'hf);
		wr(`GPAPC_IDX_PIN_EN_HI, 32'h0f);
		isa_io(16'h0201, 1'h0, 8'h00, q);
		chk(gpio_in[11:8], 4'h0);
		wr(`GPAPC_IDX_POL_HI, 32'h05);
		chk(gpio_in[11:8], 4'h5);
		ext_n <= 12'h3ff;
		wr(`GPAPC_IDX_DIR_HI, 32'h0f);
		isa_io(16'h0201, 1'h1, 8'h00, q);
		chk(q[3:0], 4'h6);
		wr(`GPAPC_IDX_ZWS_CTRL, 32'h10);
		isa_io(16'h0200, 1'h1, 8'h00, q);
		chk(q[3:0], 4'h6);
		ext_n <= 12'hfff;
		wr(`GPAPC_IDX_ZWS_CTRL, 32'h0);
		wr(`GPAPC_IDX_POL_HI, 32'h0);
		wr(`GPAPC_IDX_FSEL_HI, 32'h0);
		wr(`GPAPC_IDX_DIR_HI, 32'h0);
	endtask : t_sio
	task automatic t_zws_irq();
		wr(`GPAPC_IDX_ZWS_EN, 32'h01);
		// Zero wait needs a strobe as well as the device address.
		dev_access <= 7'h01;
		isa <= '{16'h03f0, 1'h0, 1'h1, 8'h0};
		repeat (3) @(posedge pclk);
		chk(zwn, 1'h0);
		wr(`GPAPC_IDX_ZWS_EN, 32'h0);
		chk(zwn, 1'h1);
		dev_access <= 7'h0;
		isa <= '{16'h0, 1'h1, 1'h1, 8'h0};
		// Pin enable, alternate select and location.
		wr(`GPAPC_IDX_FSEL_LO, 32'h00);
		wr(`GPAPC_IDX_PIN_EN_LO, 32'h06);
		wr(`GPAPC_IDX_DIR_LO, 32'h06);
		wr(`GPAPC_IDX_IRQ_SEL, 32'h33);
		chk(isa_irq, 16'h0008);
		ext_n <= 12'hffd;
		repeat (3) @(posedge pclk);
		chk(isa_irq, 16'h0);
		ext_n <= 12'hfff;
		wr(`GPAPC_IDX_IRQ_SEL, 32'h0);
	endtask : t_zws_irq
	// One strobe cycle on the host bus, then the chip select level on pin 0.
	task automatic cs_io(input logic [15:0] a, input logic w, input logic x);
		isa <= '{a, w, !w, 8'h0};
		repeat (3) @(posedge pclk);
		chk(gpio_in[0], x);
		isa <= '{16'h0, 1'h1, 1'h1, 8'h0};
		repeat (2) @(posedge pclk);
	endtask : cs_io
	// Chip select zero: two ports at 0x300, read qualified, on pin 0.
	task automatic t_cs();
		wr(`GPAPC_IDX_PIN_EN_LO, 32'h07);
		wr(`GPAPC_IDX_CS_MSB0, 32'h03);
		wr(`GPAPC_IDX_CS_CTRL0, 32'h51);
		rdc(`GPAPC_IDX_CS_CTRL0, 32'h51, 1'h0);
		cs_io(16'h0301, 1'h0, 1'h0);
		cs_io(16'h0302, 1'h0, 1'h1);
		cs_io(16'h0300, 1'h1, 1'h1);
		wr(`GPAPC_IDX_CS_CTRL0, 32'h0);
		rdc(`GPAPC_IDX_CS_CTRL0, 32'h0, 1'h0);
	endtask : t_cs
	task automatic t_pwr();
		press(15);
		chk(mpe_n, 1'h1);
		press(25);
		chk(mpe_n, 1'h0);
		wr(`GPAPC_IDX_PWR_LOC, 32'h72);
		press(25);
		chk(gpio_in[8], 1'h0);
		wait_pwr(1'h1, 30, 60);
		repeat (2) @(posedge pclk);
		chk(gpio_in[8], 1'h1);
		ext_n <= 12'hffb;
		repeat (3) @(posedge pclk);
		ext_n <= 12'hfff;
		repeat (10) @(posedge pclk);
		chk(mpe_n, 1'h1);
		ri1 <= 1;
		wait_pwr(1'h0, 0, 5);
		ri1 <= 0;
		wr(`GPAPC_IDX_PWR_SOFT, 32'h20);
		wait_pwr(1'h1, 0, 3);
		ri2 <= 1;
		wait_pwr(1'h0, 0, 5);
		ri2 <= 0;
		wr(`GPAPC_IDX_PWR_SOFT, 32'h20);
		wr(`GPAPC_IDX_PWR_LOC, 32'h22);
		ext_n <= 12'hffb;
		repeat (3) @(posedge pclk);
		ext_n <= 12'hfff;
		wait_pwr(1'h0, 0, 10);
		wr(`GPAPC_IDX_PWR_TIMER, 32'h41);
		press(25);
		repeat (150) @(posedge pclk);
		chk(mpe_n, 1'h0);
		wr(`GPAPC_IDX_PWR_TIMER, 32'h01);
		wait_pwr(1'h1, 60, 120);
	endtask : t_pwr
	// Reset for three cycles, then every scenario in turn.
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		t_regs();
		t_sio();
		t_zws_irq();
		t_cs();
		t_pwr();
		test_done();
	end
endmodule : gpapc_top_tb
